// ===== hdl/ddsr_host.sv
// Host controller: takes orders over AXI4-Lite and drives the synthesizer register link.
// Assumes the device on the link answers a read one cycle after the read strobe.
module ddsr_host
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   ddsr_if.host link,
   input wire logic [4:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [4:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic irq
);
   typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_READ = 3'b010, ST_DONE = 3'b100} ddsr_state_t;
   ddsr_state_t st_ff;
   logic [31:0] cmd_ff, wd_ff, rd_ff, par_ff, irq_stat_ff, irq_mask_ff;
   logic aw_ff, w_ff, bv_ff, rv_ff, go_ff, done_ev;
   logic [4:0] awa_ff;
   logic [31:0] wdt_ff;
   logic [31:0] rdo_ff;
   logic [1:0] bresp_ff, rresp_ff;
   // cmd: [6:0] addr, [7] byte mode, [8] write, [9] read, [10] update, [13:11] profile,
   // [14] master reset, [18:15] function select. Writing cmd while idle starts one link operation; a write while busy is dropped.

   ////////////////////////////////////////////////////////////////////////////////
   // AXI write channels: address and data taken in any order, response after both.
   assign s_awready = !aw_ff && !bv_ff;
   assign s_wready = !w_ff && !bv_ff;
   wire aw_hs = s_awvalid && s_awready;
   wire w_hs = s_wvalid && s_wready;
   wire wr_go = aw_ff && w_ff && !bv_ff;
   wire busy = st_ff != ST_IDLE || go_ff;
   wire wmap = awa_ff == ddsr_pkg::AXI_CMD || awa_ff == ddsr_pkg::AXI_WDATA
      || awa_ff == ddsr_pkg::AXI_IRQ_STAT || awa_ff == ddsr_pkg::AXI_IRQ_MASK;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         bv_ff <= 1'b0;
         awa_ff <= 5'h0;
         wdt_ff <= 32'h0;
         bresp_ff <= ddsr_pkg::RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (aw_hs) begin aw_ff <= 1'b1; awa_ff <= s_awaddr; end
         if (w_hs) begin w_ff <= 1'b1; wdt_ff <= s_wdata; end
         if (wr_go)
         begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bv_ff <= 1'b1;
            bresp_ff <= wmap ? ddsr_pkg::RESP_OKAY : ddsr_pkg::RESP_SLVERR;
         end
         else if (bv_ff && s_bready)
            bv_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register file; the interrupt status bit sets on a finished operation, set wins over clear.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmd_ff <= 32'h0;
         wd_ff <= 32'h0;
         irq_mask_ff <= 32'h0;
         irq_stat_ff <= 32'h0;
         go_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         go_ff <= 1'b0;
         if (wr_go && awa_ff == ddsr_pkg::AXI_CMD && !busy)
         begin
            cmd_ff <= wdt_ff;
            go_ff <= 1'b1;
         end
         if (wr_go && awa_ff == ddsr_pkg::AXI_WDATA) wd_ff <= wdt_ff;
         if (wr_go && awa_ff == ddsr_pkg::AXI_IRQ_MASK) irq_mask_ff <= {31'h0, wdt_ff[0]};
         if (wr_go && awa_ff == ddsr_pkg::AXI_IRQ_STAT)
            irq_stat_ff <= {31'h0, (irq_stat_ff[0] & ~wdt_ff[0]) | done_ev};
         else if (done_ev)
            irq_stat_ff <= 32'h1;
      end
   end
   assign irq = |(irq_stat_ff & irq_mask_ff);

   ////////////////////////////////////////////////////////////////////////////////
   // Link sequencer: one-cycle strobes, read data captured two cycles after the strobe.
   assign done_ev = st_ff == ST_DONE;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_ff <= ST_IDLE;
         rd_ff <= 32'h0;
      end
      else if (clk_en)
      begin
         case (st_ff)
            ST_IDLE: if (go_ff) st_ff <= cmd_ff[9] ? ST_READ : ST_DONE;
            ST_READ: st_ff <= ST_DONE;
            ST_DONE: begin st_ff <= ST_IDLE; if (cmd_ff[9]) rd_ff <= link.rdata; end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end
   // Master reset is raised by the host after power-up by writing cmd bit 14; the host raises it only on such a write, and the bench only in t_profile.
   // Software must keep reserved bytes at defaults and pulse calibration bits.
   assign link.wr_en = go_ff && cmd_ff[8];
   assign link.rd_en = go_ff && cmd_ff[9];
   assign link.update = go_ff && cmd_ff[10];
   assign link.master_reset = go_ff && cmd_ff[14];
   assign link.byte_mode = cmd_ff[7];
   assign link.addr = cmd_ff[6:0];
   assign link.wdata = wd_ff;
   assign link.profile = cmd_ff[13:11];
   assign link.function_select_pins = cmd_ff[18:15];
   assign link.par_data = wd_ff; // Changes only on aclk edges.

   ////////////////////////////////////////////////////////////////////////////////
   // AXI read channel.
   assign s_arready = !rv_ff;
   wire [31:0] rsel = s_araddr == ddsr_pkg::AXI_CMD ? cmd_ff : s_araddr == ddsr_pkg::AXI_WDATA ? wd_ff
      : s_araddr == ddsr_pkg::AXI_RDATA ? rd_ff : s_araddr == ddsr_pkg::AXI_STATUS ? {31'h0, busy}
      : s_araddr == ddsr_pkg::AXI_IRQ_STAT ? irq_stat_ff : s_araddr == ddsr_pkg::AXI_IRQ_MASK ? irq_mask_ff : 32'h0;
   wire rmap = s_araddr <= ddsr_pkg::AXI_IRQ_MASK && s_araddr[1:0] == 2'h0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rv_ff <= 1'b0;
         rdo_ff <= 32'h0;
         rresp_ff <= ddsr_pkg::RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (s_arvalid && s_arready)
         begin
            rv_ff <= 1'b1;
            rdo_ff <= rsel;
            rresp_ff <= rmap ? ddsr_pkg::RESP_OKAY : ddsr_pkg::RESP_SLVERR;
         end
         else if (rv_ff && s_rready)
            rv_ff <= 1'b0;
      end
   end
   assign s_bvalid = bv_ff;
   assign s_bresp = bresp_ff;
   assign s_rvalid = rv_ff;
   assign s_rdata = rdo_ff;
   assign s_rresp = rresp_ff;
endmodule

// ===== hdl/ddsr_pkg.sv
// Constants shared by both ends of the synthesizer control register link.
// Assumes one clock, aclk at 50 MHz, and a synchronous active-low reset.
package ddsr_pkg;
   // Word addresses of the serial register space.
   localparam logic [4:0] ADDR_CONTROL_WORD_ONE = 5'h00;
   localparam logic [4:0] ADDR_PROFILE_SEVEN_PHASE_GAIN = 5'h1a;
   localparam logic [4:0] ADDR_RESERVED_USER_WORD = 5'h1b;
   localparam logic [4:0] ADDR_LAST = 5'h1b;
   // Byte addresses of the parallel register space.
   localparam logic [6:0] BYTE_PHASE_LOW = 7'h68;
   localparam logic [6:0] BYTE_PHASE_HIGH = 7'h69;
   localparam logic [6:0] BYTE_GAIN_LOW = 7'h6a;
   localparam logic [6:0] BYTE_GAIN_HIGH = 7'h6b;
   localparam logic [6:0] BYTE_LAST = 7'h6f;
   // Field positions in control_word_one.
   localparam int CAL_BIT = 24;
   localparam int STREAM_BIT = 17;
   localparam int SINE_BIT = 16;
   // Writable masks and reset values.
   localparam logic [31:0] CTRL_MASK = 32'h0103_0000;
   localparam logic [31:0] CTRL_RESET = 32'h0001_0000;
   localparam logic [31:0] PROF_MASK = 32'h0fff_ffff;
   localparam logic [31:0] PROF_RESET = 32'h0000_0000;
   localparam logic [31:0] USER_MASK = 32'h00ff_ffff;
   localparam logic [31:0] USER_RESET = 32'h0000_0800;
   localparam int LOCK_BIT = 24;
   // Function select codes for the parallel port.
   localparam logic [3:0] FSEL_FREQ = 4'h0;
   localparam logic [3:0] FSEL_PHASE = 4'h1;
   localparam logic [3:0] FSEL_GAIN = 4'h2;
   // Controller registers on AXI4-Lite, byte addresses.
   localparam logic [4:0] AXI_CMD = 5'h00;
   localparam logic [4:0] AXI_WDATA = 5'h04;
   localparam logic [4:0] AXI_RDATA = 5'h08;
   localparam logic [4:0] AXI_STATUS = 5'h0c;
   localparam logic [4:0] AXI_IRQ_STAT = 5'h10;
   localparam logic [4:0] AXI_IRQ_MASK = 5'h14;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/ddsr_if.sv
// Link between the host controller and the synthesizer register bank.
// Assumes both ends share aclk; all signals are synchronous to it.
interface ddsr_if;
   logic wr_en; // One-cycle register write strobe.
   logic rd_en; // One-cycle register read strobe.
   logic byte_mode; // High: byte access on parallel address.
   logic [6:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic update; // Transfer strobe.
   logic [2:0] profile; // Profile select pins.
   logic master_reset;
   logic [31:0] par_data; // Parallel data port.
   logic [3:0] function_select_pins;
   modport dev (input wr_en, rd_en, byte_mode, addr, wdata, update, profile, master_reset, par_data,
      function_select_pins, output rdata);
   modport host (output wr_en, rd_en, byte_mode, addr, wdata, update, profile, master_reset, par_data,
      function_select_pins, input rdata);
endinterface

// ===== hdl/ddsr_device.sv
// Register bank of the synthesizer: control word one, profile seven phase and gain, reserved user word.
// Assumes the host drives the link on aclk; the core sync clock is aclk gated by clk_en.
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Decode 28 word, 112 byte registers.
// - Phase word at bytes 0x68, 0x69.
// - Gain at 0x6A plus low nibble 0x6B.
// - Host keeps reserved bytes at defaults.
// - Master reset restores all defaults.
// - Host pulses converter calibration after power-up.
// - Writes buffered until strobe or profile change.
// - Bit 24 rising starts PLL calibration.
// - Calibration needs fresh zero-to-one transition.
// - Streaming off: parallel data on strobe.
// - Streaming on: sample every edge, route.
// - Host aligns streamed data to edge.
// - Select bit zero gives cosine output.
// - Select bit one gives sine, default.
module ddsr_device
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   ddsr_if.dev link,
   input wire logic pll_locked,
   output logic pll_cal_start,
   output logic sine_select,
   output logic stream_mode,
   output logic [31:0] freq_tuning_word,
   output logic [15:0] phase_offset_word,
   output logic [11:0] gain_scale
);
   logic [31:0] buf_ctrl_ff, buf_prof_ff, buf_user_ff;
   logic [31:0] act_ctrl_ff, act_prof_ff;
   logic [31:0] ftw_ff;
   logic [15:0] pow_ff;
   logic [11:0] amp_ff;
   logic [31:0] rdata_ff;
   logic [2:0] prof_ff;
   logic cal_prev_ff, cal_pulse_ff;
   logic nxt_cal_pulse;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode: word access uses addr[4:0], byte access maps byte n onto word n/4, lane n%4.
   wire [4:0] word_idx = link.byte_mode ? link.addr[6:2] : link.addr[4:0];
   wire [1:0] lane = link.addr[1:0];
   wire in_range = link.byte_mode ? (link.addr <= ddsr_pkg::BYTE_LAST)
                                  : (link.addr[6:5] == 2'h0 && link.addr[4:0] <= ddsr_pkg::ADDR_LAST);
   wire [31:0] lane_mask = link.byte_mode ? (32'h0000_00ff << {lane, 3'h0}) : 32'hffff_ffff;
   wire [31:0] lane_data = link.byte_mode ? ({24'h0, link.wdata[7:0]} << {lane, 3'h0}) : link.wdata;
   wire hit_ctrl = in_range && word_idx == ddsr_pkg::ADDR_CONTROL_WORD_ONE;
   wire hit_prof = in_range && word_idx == ddsr_pkg::ADDR_PROFILE_SEVEN_PHASE_GAIN;
   wire hit_user = in_range && word_idx == ddsr_pkg::ADDR_RESERVED_USER_WORD;
   wire wr_ctrl = link.wr_en && hit_ctrl;
   wire wr_prof = link.wr_en && hit_prof;
   wire wr_user = link.wr_en && hit_user;
   // A transfer happens on the strobe or on any change of the profile pins.
   wire xfer = link.update || (link.profile != prof_ff);
   wire streaming = act_ctrl_ff[ddsr_pkg::STREAM_BIT];

   // Merge a write into a buffer; open bits are forced to zero by the mask.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask);
      merge = ((old & ~lane_mask) | (lane_data & lane_mask)) & mask;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Buffered registers, and active copies of the control and profile words.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || link.master_reset)
      begin
         buf_ctrl_ff <= ddsr_pkg::CTRL_RESET;
         buf_prof_ff <= ddsr_pkg::PROF_RESET;
         buf_user_ff <= ddsr_pkg::USER_RESET;
         act_ctrl_ff <= ddsr_pkg::CTRL_RESET;
         act_prof_ff <= ddsr_pkg::PROF_RESET;
         prof_ff <= 3'h0;
      end
      else if (clk_en)
      begin
         if (wr_ctrl) buf_ctrl_ff <= merge(buf_ctrl_ff, ddsr_pkg::CTRL_MASK);
         if (wr_prof) buf_prof_ff <= merge(buf_prof_ff, ddsr_pkg::PROF_MASK);
         if (wr_user) buf_user_ff <= merge(buf_user_ff, ddsr_pkg::USER_MASK);
         prof_ff <= link.profile;
         if (xfer)
         begin
            act_ctrl_ff <= buf_ctrl_ff;
            act_prof_ff <= buf_prof_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // PLL calibration starts only on a fresh rising edge of the active bit.
   assign nxt_cal_pulse = act_ctrl_ff[ddsr_pkg::CAL_BIT] && !cal_prev_ff;
   always_ff @(posedge aclk)
   begin
      if (!aresetn || link.master_reset)
      begin
         cal_prev_ff <= 1'b0;
         cal_pulse_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         cal_prev_ff <= act_ctrl_ff[ddsr_pkg::CAL_BIT];
         cal_pulse_ff <= nxt_cal_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Parallel port: streaming samples each edge, otherwise only on the transfer strobe.
   // Streaming bypasses the buffer, so the host must meet the edge timing itself.
   wire par_take = streaming ? 1'b1 : link.update;
   always_ff @(posedge aclk)
   begin
      if (!aresetn || link.master_reset)
      begin
         ftw_ff <= 32'h0;
         pow_ff <= 16'h0;
         amp_ff <= 12'h0;
      end
      else if (clk_en)
      begin
         if (par_take && link.function_select_pins == ddsr_pkg::FSEL_FREQ)
            ftw_ff <= link.par_data;
         if (par_take && link.function_select_pins == ddsr_pkg::FSEL_PHASE)
            pow_ff <= link.par_data[15:0];
         else if (xfer && !streaming)
            pow_ff <= buf_prof_ff[15:0];
         if (par_take && link.function_select_pins == ddsr_pkg::FSEL_GAIN)
            amp_ff <= link.par_data[11:0];
         else if (xfer && !streaming)
            amp_ff <= buf_prof_ff[27:16];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Readback shows buffered contents; the lock bit is live.
   wire [31:0] user_rd = buf_user_ff | ({31'h0, pll_locked} << ddsr_pkg::LOCK_BIT);
   wire [31:0] word_rd = hit_ctrl ? buf_ctrl_ff : hit_prof ? buf_prof_ff : hit_user ? user_rd : 32'h0;
   wire [31:0] sel_rd = link.byte_mode ? {24'h0, 8'(word_rd >> {lane, 3'h0})} : word_rd;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rdata_ff <= 32'h0;
      else if (clk_en && link.rd_en)
         rdata_ff <= sel_rd;
   end

   assign link.rdata = rdata_ff;
   assign pll_cal_start = cal_pulse_ff;
   assign sine_select = act_ctrl_ff[ddsr_pkg::SINE_BIT];
   assign stream_mode = streaming;
   assign freq_tuning_word = ftw_ff;
   assign phase_offset_word = pow_ff;
   assign gain_scale = amp_ff;
endmodule

// ===== verification/ddsr_checker.sv
// Concurrent checks on the register link between the host controller and the synthesizer bank.
// Assumes one clock, aclk, a synchronous active-low aresetn, and signals wired in by name.
module ddsr_checker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic byte_mode,
   input wire logic [6:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [31:0] rdata,
   input wire logic update,
   input wire logic [2:0] profile,
   input wire logic master_reset,
   input wire logic [31:0] par_data,
   input wire logic [3:0] function_select_pins,
   input wire logic pll_locked,
   input wire logic pll_cal_start,
   input wire logic sine_select,
   input wire logic stream_mode,
   input wire logic [31:0] freq_tuning_word,
   input wire logic [15:0] phase_offset_word,
   input wire logic [11:0] gain_scale
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Decoded link events; quiet means no strobe, master reset or streaming may move the active values.
   wire word_rd = rd_en && !byte_mode;
   wire far_rd = rd_en && (byte_mode ? addr > ddsr_pkg::BYTE_LAST : addr > 7'h1b);
   wire quiet = !update && !master_reset && !stream_mode;
   ////////////////////////////////////////////////////////////////////////////////
   // A calibration start is a lone pulse; a fresh rising edge needs a new host write and strobe.
   sequence s_cal_quiet;
      !pll_cal_start [*3];
   endsequence
   sequence s_defaults;
      sine_select && !stream_mode && freq_tuning_word == 32'h0 && phase_offset_word == 16'h0 && gain_scale == 12'h0;
   endsequence
   property p_far_read;
      far_rd |=> rdata == 32'h0;
   endproperty
   property p_ctrl_read;
      word_rd && addr == 7'h00 |=> (rdata & ~ddsr_pkg::CTRL_MASK) == 32'h0;
   endproperty
   property p_prof_read;
      word_rd && addr == 7'h1a |=> rdata[31:28] == 4'h0;
   endproperty
   property p_lock_read;
      word_rd && addr == 7'h1b |=> rdata[31:24] == {7'h0, $past(pll_locked)};
   endproperty
   property p_user_keep;
      wr_en && !byte_mode && addr == 7'h1b |-> wdata[23:0] == 24'h00_0800;
   endproperty
   property p_cal;
      pll_cal_start |=> s_cal_quiet;
   endproperty
   property p_mreset;
      master_reset |=> s_defaults;
   endproperty
   // Without a strobe or a profile change the tuning word, phase offset and sine select must stand still.
   property p_hold;
      quiet && $stable(profile) ##1 $stable(profile) |-> $stable(freq_tuning_word) && $stable(phase_offset_word)
         && $stable(sine_select);
   endproperty
   property p_stream;
      stream_mode && !update && !master_reset && function_select_pins == ddsr_pkg::FSEL_FREQ
         |=> freq_tuning_word == $past(par_data);
   endproperty
   a_far_read: assert property (p_far_read) else $error("out of range read gave data");
   a_ctrl_read: assert property (p_ctrl_read) else $error("open control bits read set");
   a_prof_read: assert property (p_prof_read) else $error("open gain bits read set");
   a_lock_read: assert property (p_lock_read) else $error("lock bit not live");
   a_user_keep: assert property (p_user_keep) else $error("reserved bytes changed");
   a_cal: assert property (p_cal) else $error("calibration pulse repeated");
   a_mreset: assert property (p_mreset) else $error("master reset left values");
   a_hold: assert property (p_hold) else $error("active value moved without strobe");
   a_stream: assert property (p_stream) else $error("streamed word not taken");
endmodule

// ===== verification/tb_top.sv
// Self-checking bench: AXI4-Lite orders reach the host, which drives the synthesizer bank over the link.
// Assumes the package, the interface and both design ends are compiled first.
`define CK(nm, ex, got) \
   begin \
      checks_done++; \
      if ((got) !== (ex)) \
      begin \
         errors++; \
         $display("unexpected %s expected %h seen %h", nm, ex, got); \
      end \
   end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0, aresetn = 1'b0, pll_locked = 1'b0;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
   logic [4:0] s_awaddr = 5'h0, s_araddr = 5'h0;
   logic [31:0] s_wdata = 32'h0, s_rdata, d;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, pll_cal_start, sine_select, stream_mode;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] freq_tuning_word;
   logic [15:0] phase_offset_word;
   logic [11:0] gain_scale;
   logic [2:0] cur_prof = 3'h0;
   logic [3:0] cur_fsel = 4'h0;
   int errors = 0, checks_done = 0, cal_cnt = 0;
   ddsr_if link_if();
   ////////////////////////////////////////////////////////////////////////////////
   // Both ends face each other; the core sync enable is tied high, so every edge samples.
   ddsr_device ddsr_device_i (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .link(link_if.dev),
      .pll_locked(pll_locked), .pll_cal_start(pll_cal_start), .sine_select(sine_select), .stream_mode(stream_mode),
      .freq_tuning_word(freq_tuning_word), .phase_offset_word(phase_offset_word), .gain_scale(gain_scale));
   ddsr_host ddsr_host_i (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .link(link_if.host), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
      .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .irq(irq));
   ddsr_checker ddsr_checker_i (.aclk(aclk), .aresetn(aresetn), .wr_en(link_if.wr_en), .rd_en(link_if.rd_en),
      .byte_mode(link_if.byte_mode), .addr(link_if.addr), .wdata(link_if.wdata), .rdata(link_if.rdata),
      .update(link_if.update), .profile(link_if.profile), .master_reset(link_if.master_reset),
      .par_data(link_if.par_data), .function_select_pins(link_if.function_select_pins), .pll_locked(pll_locked),
      .pll_cal_start(pll_cal_start), .sine_select(sine_select), .stream_mode(stream_mode),
      .freq_tuning_word(freq_tuning_word), .phase_offset_word(phase_offset_word), .gain_scale(gain_scale));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock of 20 ns, and a count of calibration pulses so a missing or doubled one is seen.
   initial
   begin
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      if (pll_cal_start === 1'b1) cal_cnt++;
   end
   task automatic wrap_up();
   begin
      if (errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   end
   endtask
   // A wait that used up its bound ends the run rather than hanging it.
   task automatic bound(input int n);
   begin
      if (n >= 40)
      begin
         errors++;
         wrap_up();
      end
   end
   endtask
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] ex);
      int n;
      begin
         n = 0;
         @(posedge aclk);
         s_awaddr <= a;
         s_wdata <= v;
         s_awvalid <= 1'b1;
         s_wvalid <= 1'b1;
         s_bready <= 1'b1;
         do
         begin
            @(posedge aclk);
            n++;
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
         end while (!s_bvalid && n < 40);
         s_bready <= 1'b0;
         bound(n);
         `CK("bresp", ex, s_bresp)
      end
   endtask
   task automatic axi_rd(input logic [4:0] a, input logic [1:0] ex);
      int n;
      begin
         n = 0;
         @(posedge aclk);
         s_araddr <= a;
         s_arvalid <= 1'b1;
         s_rready <= 1'b1;
         do
         begin
            @(posedge aclk);
            n++;
            if (s_arready) s_arvalid <= 1'b0;
         end while (!s_rvalid && n < 40);
         s_rready <= 1'b0;
         d = s_rdata;
         bound(n);
         `CK("rresp", ex, s_rresp)
      end
   endtask
   // Polls the sticky done flag; busy status alone could already be clear again by the time it is read.
   task automatic wait_done();
      int n;
      begin
         n = 0;
         d = 32'h0;
         while (d[0] !== 1'b1 && n < 40)
         begin
            axi_rd(5'h10, 2'h0);
            n++;
         end
         bound(n);
      end
   endtask
   // Op bits are master reset, update, read, write; profile and function select always ride along.
   task automatic link_op(input logic [6:0] a, input logic [3:0] op);
   begin
      axi_wr(5'h00, {13'h0, cur_fsel, op[3], cur_prof, op[2:0], 1'b0, a}, 2'h0);
      wait_done();
      axi_wr(5'h10, 32'h1, 2'h0);
   end
   endtask
   task automatic link_wr(input logic [6:0] a, input logic [31:0] v);
   begin
      axi_wr(5'h04, v, 2'h0);
      link_op(a, 4'h1);
   end
   endtask
   task automatic link_rd(input logic [6:0] a);
   begin
      link_op(a, 4'h2);
      axi_rd(5'h08, 2'h0);
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_ctrl();
   begin
      `CK("sine", 1'b1, sine_select)
      link_rd(7'h00);
      `CK("ctrl", ddsr_pkg::CTRL_RESET, d)
      link_rd(7'h1a);
      `CK("prof", 32'h0, d)
      link_wr(7'h00, 32'hffff_ffff);
      link_rd(7'h00);
      `CK("ctrl mask", 32'h0103_0000, d)
      `CK("held", 1'b0, stream_mode)
      `CK("par held", 32'h0, freq_tuning_word)
      link_op(7'h00, 4'h4);
      `CK("par load", 32'hffff_ffff, freq_tuning_word)
      `CK("cal", 1, cal_cnt)
      link_op(7'h00, 4'h4);
      `CK("cal again", 1, cal_cnt)
      link_wr(7'h00, 32'h0);
      `CK("streamed", 32'h0, freq_tuning_word)
      link_op(7'h00, 4'h4);
      `CK("cosine", 1'b0, sine_select)
      link_wr(7'h00, 32'h0101_0000);
      link_op(7'h00, 4'h4);
      `CK("cal fresh", 2, cal_cnt)
      `CK("sine", 1'b1, sine_select)
   end
   endtask
   task automatic t_profile();
   begin
      link_wr(7'h1a, 32'hf5a5_1234);
      link_rd(7'h1a);
      `CK("prof mask", 32'h05a5_1234, d)
      `CK("phase held", 16'h0, phase_offset_word)
      cur_prof = 3'h7;
      link_op(7'h00, 4'h0);
      `CK("phase", 16'h1234, phase_offset_word)
      `CK("gain", 12'h5a5, gain_scale)
      `CK("ftw kept", 32'h0101_0000, freq_tuning_word)
      link_op(7'h00, 4'h8);
      `CK("rst phase", 16'h0, phase_offset_word)
      link_rd(7'h1a);
      `CK("rst prof", 32'h0, d)
   end
   endtask
   task automatic t_stream();
   begin
      link_wr(7'h00, 32'h0002_0000);
      link_op(7'h00, 4'h4);
      cur_fsel = ddsr_pkg::FSEL_PHASE;
      link_op(7'h00, 4'h0);
      axi_wr(5'h04, 32'h0000_beef, 2'h0);
      link_op(7'h00, 4'h0);
      `CK("str phase", 16'hbeef, phase_offset_word)
      `CK("str ftw", 32'h0002_0000, freq_tuning_word)
      cur_fsel = ddsr_pkg::FSEL_FREQ;
      link_wr(7'h00, 32'h0001_0000);
      link_op(7'h00, 4'h4);
      `CK("str off", 1'b0, stream_mode)
      pll_locked <= 1'b1;
      link_wr(7'h1b, 32'hff00_0800);
      link_rd(7'h1b);
      `CK("lock", 32'h0100_0800, d)
      link_rd(7'h1c);
      `CK("far", 32'h0, d)
   end
   endtask
   task automatic t_irq();
   begin
      axi_wr(5'h18, 32'h1, ddsr_pkg::RESP_SLVERR);
      axi_rd(5'h18, ddsr_pkg::RESP_SLVERR);
      axi_wr(5'h14, 32'h1, 2'h0);
      axi_wr(5'h00, {18'h0, cur_prof, 11'h0}, 2'h0);
      wait_done();
      `CK("irq", 1'b1, irq)
      axi_wr(5'h14, 32'h0, 2'h0);
      `CK("irq mask", 1'b0, irq)
      axi_wr(5'h10, 32'h1, 2'h0);
      axi_rd(5'h10, 2'h0);
      `CK("stat", 1'b0, d[0])
   end
   endtask
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_ctrl();
      t_profile();
      t_stream();
      t_irq();
      wrap_up();
   end
endmodule
